// File: rtl/sai_rx.sv
// Notes on behaviour
// - stereo: left captured while word clock equals polarity bit, right otherwise
// - tdm, polarity 0: frame starts at sample edge after word clock falls
// - tdm, polarity 1: frame starts at sample edge after word clock rises
// - a word clock pulse is accepted; its first edge starts the frame
// - edge select 0: data changes on falling, sampled on rising; 1 reversed
// - polarity bits override format bits; all five are written in one access
// - justified formats expect word clock high for left, i.e. polarity set
// - tdm slot msb comes one bit clock after slot start
// - tdm slots 0-3 fill first half, 4-7 second half, eight per frame
// - format codes: 000 i2s, 001 left, 010 tdm, 011 right 24, wider shorter
//
// Chosen here: the address map and the address-and-strobe port.
`default_nettype none
module sai_rx
    import sai_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  bit_clock_in,
    input  wire logic                  word_clock_in,
    input  wire logic [SAI_LANES-1:0]  serial_data_inputs,
    input  wire logic [11:0]           reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [7:0]            reg_rdata,
    output var  logic                  word_valid,
    input  wire logic                  word_ready,
    output var  logic [2:0]            word_chan,
    output var  logic [23:0]           word_data
);
    // =====================================================================
    // control and status registers
    sai_ctrl_t ctrl_r;
    logic      ovf_r;
    logic      locked_r;
    logic      ovf_evt;
    logic      ctrl_wr;
    logic      stat_wr;

    assign ctrl_wr = reg_wr && (reg_addr == SAI_CTRL_ADDR);
    assign stat_wr = reg_wr && (reg_addr == SAI_STAT_ADDR);

    // one write moves polarity, edge and format together
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= sai_ctrl_t'(SAI_CTRL_RESET[4:0]);
        end else if (ctrl_wr) begin
            ctrl_r <= sai_ctrl_t'(reg_wdata[4:0]);
        end
    end

    // sticky overflow: a new loss beats a same-cycle write-one clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_r <= 1'b0;
        end else if (ovf_evt) begin
            ovf_r <= 1'b1;
        end else if (stat_wr && reg_wdata[SAI_OVF_BIT]) begin
            ovf_r <= 1'b0;
        end
    end

    // =====================================================================
    // pin synchronisers and bit clock edge detection
    logic [SAI_LANES+1:0] pins_s;
    logic                 bclk_d_r;
    logic                 bclk_s;
    logic                 lr_s;
    logic [SAI_LANES-1:0] sd_s;

    sai_sync #(
        .W (SAI_LANES + 2)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     ({bit_clock_in, word_clock_in, serial_data_inputs}),
        .dout    (pins_s)
    );

    assign bclk_s = pins_s[SAI_LANES+1];
    assign lr_s   = pins_s[SAI_LANES];
    assign sd_s   = pins_s[SAI_LANES-1:0];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) bclk_d_r <= 1'b0;
        else         bclk_d_r <= bclk_s;
    end

    // =====================================================================
    // frame decode; the bit counter and last word clock level advance only on the sample edge
    logic       smp;
    logic       is_tdm;
    logic       is_i2s;
    logic       is_rj;
    logic       pol;
    logic       lr_prev_r;
    logic       lr_chg;
    logic       frame_start;
    logic       stereo_bnd;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] pos;
    logic       delay;
    logic [4:0] rj_pad;

    // sample on the edge opposite the one where the source changes data
    assign smp = ctrl_r.bit_clock_edge_sel ? (bclk_d_r && !bclk_s)
                                           : (bclk_s && !bclk_d_r);

    assign is_tdm = (ctrl_r.fmt == SAI_FMT_TDM);
    assign is_i2s = (ctrl_r.fmt == SAI_FMT_I2S);
    assign is_rj  = ctrl_r.fmt[2] || (ctrl_r.fmt == SAI_FMT_RJ24);
    // justified formats are run with polarity set, so left is the high phase
    assign pol    = ctrl_r.word_clock_polarity_sel;
    assign lr_chg = smp && (lr_s != lr_prev_r);

    // tdm: only the edge into the polarity level starts a frame, so a
    // pulse is caught on its leading edge and its trailing edge is ignored
    assign frame_start = is_tdm && lr_chg && (lr_s == pol);
    assign stereo_bnd  = !is_tdm && lr_chg;

    // msb sits one bit clock after the slot start in i2s and tdm
    assign delay = is_tdm || is_i2s;

    always_comb begin
        unique case (ctrl_r.fmt)
            SAI_FMT_RJ20:  rj_pad = 5'h04;
            SAI_FMT_RJ18:  rj_pad = 5'h06;
            SAI_FMT_RJ16A: rj_pad = 5'h08;
            SAI_FMT_RJ16B: rj_pad = 5'h08;
            default:       rj_pad = 5'h00;
        endcase
    end

    always_comb begin
        if (frame_start || stereo_bnd) begin
            cnt_nxt = 8'h00;
        end else if (cnt_r == SAI_CNT_MAX && !is_tdm) begin
            cnt_nxt = cnt_r; // long stereo halves saturate
        end else begin
            cnt_nxt = cnt_r + 8'h01; // tdm wraps after 256 bit clocks
        end
    end

    // position inside the current word; tdm slots are 32 bit clocks wide
    assign pos = is_tdm ? {3'h0, cnt_nxt[4:0]} : cnt_nxt;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r     <= 8'h00;
            lr_prev_r <= 1'b0;
        end else if (smp) begin
            cnt_r     <= cnt_nxt;
            lr_prev_r <= lr_s;
        end
    end

    // lock after the first frame marker; any control write forces relock,
    // but a marker in the same cycle wins, like every hardware-set flag
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            locked_r <= 1'b0;
        end else if (frame_start || stereo_bnd) begin
            locked_r <= 1'b1;
        end else if (ctrl_wr) begin
            locked_r <= 1'b0;
        end
    end

    // =====================================================================
    // per-lane word assembly, msb first
    logic [23:0] acc_r [SAI_LANES];
    logic [23:0] shr_r [SAI_LANES];
    sai_word_t   fin   [SAI_LANES];
    logic [7:0]  widx;
    logic        wr_bit;
    logic        i2s_tail;
    logic        old_right;

    assign widx      = pos - {7'h00, delay};
    assign wr_bit    = (pos >= {7'h00, delay}) && (widx < 8'(SAI_WORD_BITS));
    assign i2s_tail  = is_i2s && (cnt_r < 8'(SAI_WORD_BITS));
    assign old_right = (lr_prev_r != pol);

    genvar k;
    generate
        for (k = 0; k < SAI_LANES; k++) begin : g_lane
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    acc_r[k] <= 24'h000000;
                    shr_r[k] <= 24'h000000;
                end else if (smp) begin
                    shr_r[k] <= {shr_r[k][22:0], sd_s[k]};
                    if (pos == 8'h00) begin
                        acc_r[k] <= wr_bit ? {sd_s[k], 23'h000000} : 24'h000000;
                    end else if (wr_bit) begin
                        acc_r[k][5'd23 - widx[4:0]] <= sd_s[k];
                    end
                end
            end

            // finished word at a stereo boundary: in i2s the boundary bit
            // is still the old word's tail, in left justified it is the new msb
            always_comb begin
                fin[k].chan = {2'(k), old_right};
                if (is_rj) begin
                    fin[k].data = shr_r[k] << rj_pad;
                end else if (i2s_tail) begin
                    fin[k].data = acc_r[k]
                                | ({23'h000000, sd_s[k]} << (5'd23 - cnt_r[4:0]));
                end else begin
                    fin[k].data = acc_r[k];
                end
            end
        end
    endgenerate

    // =====================================================================
    // pending words, drained one per clock into the fifo
    sai_word_t            pend_r [SAI_LANES];
    logic [SAI_LANES-1:0] pend_v_r;
    logic                 tdm_emit;
    logic                 st_emit;
    logic [1:0]           sel;
    logic                 fifo_in_ready;
    sai_word_t            fifo_out;
    logic                 fifo_out_valid;

    // the slot's 24th bit was sampled this edge
    assign tdm_emit = smp && is_tdm && locked_r && (pos == SAI_TDM_LAST);
    assign st_emit  = stereo_bnd && locked_r;

    // a new emit while words are still waiting means the core fell behind
    assign ovf_evt = (tdm_emit || st_emit) && (pend_v_r != '0);

    always_comb begin
        sel = 2'd0;
        for (int i = SAI_LANES - 1; i >= 0; i--) begin
            if (pend_v_r[i]) sel = 2'(i);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_v_r <= '0;
            for (int i = 0; i < SAI_LANES; i++) pend_r[i] <= '0;
        end else if (tdm_emit) begin
            // tdm uses lane 0 only; the other inputs are ignored
            pend_v_r     <= 4'h1;
            pend_r[0]    <= '{chan: cnt_nxt[7:5], data: {acc_r[0][23:1], sd_s[0]}};
        end else if (st_emit) begin
            pend_v_r <= 4'hf;
            for (int i = 0; i < SAI_LANES; i++) pend_r[i] <= fin[i];
        end else if (fifo_in_ready) begin
            pend_v_r[sel] <= 1'b0; // fifo full stalls the drain
        end
    end

    sai_fifo #(
        .W     ($bits(sai_word_t)),
        .DEPTH (SAI_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (pend_v_r[sel]),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_r[sel]),
        .out_valid (fifo_out_valid),
        .out_ready (word_ready),
        .out_data  (fifo_out)
    );

    assign word_valid = fifo_out_valid;
    assign word_chan  = fifo_out.chan;
    assign word_data  = fifo_out.data;

    // =====================================================================
    // register read port: data valid in the cycle after the strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == SAI_CTRL_ADDR) begin
                reg_rdata <= {3'h0, ctrl_r};
            end else if (reg_addr == SAI_STAT_ADDR) begin
                reg_rdata <= {5'h00, lr_s, locked_r, ovf_r};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // sai_rx
`default_nettype wire

// File: rtl/sai_pkg.sv
`default_nettype none
package sai_pkg;
    // =====================================================================
    // register map (word offsets on the plain register port)
    localparam logic [11:0] SAI_CTRL_ADDR   = 12'h81f;
    localparam logic [11:0] SAI_STAT_ADDR   = 12'h820;
    localparam logic [7:0]  SAI_CTRL_RESET  = 8'h00;
    localparam int          SAI_FMT_LSB     = 0;
    localparam int          SAI_EDGE_BIT    = 3;
    localparam int          SAI_POL_BIT     = 4;
    localparam int          SAI_OVF_BIT     = 0;
    localparam int          SAI_LOCK_BIT    = 1;
    localparam int          SAI_WCLK_BIT    = 2;

    // =====================================================================
    // data shape and frame geometry
    localparam int          SAI_LANES       = 4;
    localparam int          SAI_WORD_BITS   = 24;
    localparam int          SAI_FIFO_DEPTH  = 16;
    localparam logic [7:0]  SAI_CNT_MAX     = 8'hff;
    localparam logic [7:0]  SAI_TDM_LAST    = 8'h18;  // slot position of the 24th bit

    // =====================================================================
    // format field codes
    typedef enum logic [2:0] {
        SAI_FMT_I2S   = 3'b000,
        SAI_FMT_LJ    = 3'b001,
        SAI_FMT_TDM   = 3'b010,
        SAI_FMT_RJ24  = 3'b011,
        SAI_FMT_RJ20  = 3'b100,
        SAI_FMT_RJ18  = 3'b101,
        SAI_FMT_RJ16A = 3'b110,
        SAI_FMT_RJ16B = 3'b111
    } sai_fmt_t;

    typedef struct packed {
        logic       word_clock_polarity_sel;
        logic       bit_clock_edge_sel;
        sai_fmt_t   fmt;
    } sai_ctrl_t;

    typedef struct packed {
        logic [2:0]  chan;
        logic [23:0] data;
    } sai_word_t;
endpackage : sai_pkg
`default_nettype wire

// File: rtl/sai_sync.sv
`default_nettype none
module sai_sync
    import sai_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    // =====================================================================
    // two-stage synchroniser; stage one feeds only stage two
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // sai_sync
`default_nettype wire

// File: rtl/sai_fifo.sv
`default_nettype none
module sai_fifo
    import sai_pkg::*;
#(
    parameter int W     = 27,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // =====================================================================
    // storage plus a registered output stage
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0]   count_r;
    logic          push;
    logic          pop;

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = (count_r != '0) && (!out_valid || out_ready);

    // write side
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end else begin
            if (push) wptr_r <= wptr_r + 1'b1;
            if (pop)  rptr_r <= rptr_r + 1'b1;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // output register holds a word until the drain side takes it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rptr_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule // sai_fifo
`default_nettype wire

// File: verif/sai_rx_assertions.sv
`default_nettype none
// =====================================================================
// port checks for the serial audio receiver
module sai_rx_chk
    import sai_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        word_valid,
    input wire logic        word_ready,
    input wire logic [2:0]  word_chan,
    input wire logic [23:0] word_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic [4:0] ctrl_r;

    // shadow of the control bits; the three top bits are never stored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            ctrl_r <= SAI_CTRL_RESET[4:0];
        else if (reg_wr && reg_addr == SAI_CTRL_ADDR)
            ctrl_r <= reg_wdata[4:0];
    end

    // =====================================================================
    // register port
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside an answer");
    chk_ctrl_readback: assert property (
        $past(reg_rd) && $past(reg_addr) == SAI_CTRL_ADDR |-> reg_rdata == {3'h0, $past(ctrl_r)})
        else $error("control readback differs from last write");
    chk_unmapped_zero: assert property (
        $past(reg_rd) && $past(reg_addr) != SAI_CTRL_ADDR && $past(reg_addr) != SAI_STAT_ADDR
        |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_stat_upper: assert property (
        $past(reg_rd) && $past(reg_addr) == SAI_STAT_ADDR |-> reg_rdata[7:3] == 5'h00)
        else $error("status spare bits not zero");

    // =====================================================================
    // word stream
    chk_word_held: assert property (word_valid && !word_ready |=> word_valid)
        else $error("offered word withdrawn");
    chk_word_stable: assert property (
        word_valid && !word_ready |=> $stable(word_chan) && $stable(word_data))
        else $error("offered word changed before taken");
    chk_rj_zero_fill: assert property (
        word_valid && ctrl_r[2]
        |-> (word_data << (ctrl_r[1] ? 16 : ctrl_r[0] ? 18 : 20)) == 24'h000000)
        else $error("short word not zero filled");
    chk_quiet_reset: assert property ($fell(sys_rst) |-> !word_valid [*8])
        else $error("word offered before any frame");
endmodule // sai_rx_chk

bind sai_rx sai_rx_chk sai_rx_chk_inst (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .word_valid, .word_ready, .word_chan, .word_data
);
`default_nettype wire

// File: verif/sai_src_model.sv
`default_nettype none
// =====================================================================
// far-side audio source; its bit clock stands still outside frames and the two priming ticks
module sai_src_model (
    output var logic       bclk,
    output var logic       wclk,
    output var logic [3:0] sd
);
    timeunit 1ns;
    timeprecision 1ns;

    // pins start parked
    initial begin
        bclk = 1'b0;
        wclk = 1'b1;
        sd = 4'h0;
    end

    // one 160 ns bit: change edge, then sample edge half a period later
    task automatic tick(input logic e, input logic lv, input logic [3:0] d);
        bclk = e;
        wclk = lv;
        sd = d;
        #80;
        bclk = !e;
        #80;
    endtask

    // park the word clock off-frame and show it to the old setup, so the
    // receiver's last seen level is known before it is reconfigured; two
    // ticks make both bit clock edges happen whichever one it samples on
    task automatic prime(input logic e, input logic p);
        wclk = !p;
        #83;
        repeat (2)
            tick(e, !p, ~sd);
    endtask

    // one frame: stereo 2x32 bits on every lane, tdm 8x32 bits on lane 0
    task automatic run(input logic t, input logic p, input logic e, input logic u,
                       input int s, input int n, input logic [23:0] w[8]);
        logic [3:0] d;
        int         q;
        int         j;
        for (q = 0; q < (t ? 256 : 64); q++) begin
            for (int k = 0; k < 4; k++) begin
                j = t ? q / 32 : 2 * k + q / 32;
                d[k] = q[0] ^ k[0];  // filler toggles, never a held value
                if ((k == 0 || !t) && q % 32 >= s && q % 32 < s + n)
                    d[k] = w[j][23 - q % 32 + s];
            end
            tick(e, (t ? (u ? q == 0 : q < 128) : q < 32) ? p : !p, d);
        end
        if (!t)
            tick(e, p, ~d);  // closing boundary releases the right words
    endtask
endmodule // sai_src_model
`default_nettype wire

// File: verif/test_sai_rx.sv
`default_nettype none
module test_sai_rx
    import sai_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, sys_rst, bclk, wclk, reg_wr, reg_rd, word_valid, word_ready;
    logic        hold, discard;
    logic [3:0]  sd;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [2:0]  word_chan;
    logic [23:0] word_data;
    logic [31:0] rnd;
    logic [26:0] exp_q[$];
    int          n_errors = 0;
    int          comparisons = 0;
    // {pulse, polarity, edge, format}; justified formats run with polarity 1
    logic [5:0]  cfg[12] = '{6'h00, 6'h19, 6'h02, 6'h1a, 6'h32, 6'h2a,
                             6'h13, 6'h1c, 6'h15, 6'h1e, 6'h17, 6'h18};

    sai_rx sai_rx_inst (
        .clk, .sys_rst, .bit_clock_in(bclk), .word_clock_in(wclk),
        .serial_data_inputs(sd), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .word_valid, .word_ready, .word_chan, .word_data);
    sai_src_model sai_src_model_inst (.bclk, .wclk, .sd);

    // =====================================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", e, reg_rdata & m);
    endtask

    // one frame of random words, expected channel order pushed alongside
    task automatic send(input logic [5:0] c, input bit push);
        logic [23:0] w[8];
        int          n;
        int          s;
        int          j;
        n = c[2] ? (c[1] ? 16 : (c[0] ? 18 : 20)) : 24;
        s = (c[2] || c[1:0] == 2'b11) ? 32 - n : int'(c[1:0] != 2'b01);
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            j = c[2:0] == SAI_FMT_TDM ? k : k % 4 * 2 + k / 4;
            w[j] = rnd[23:0] & (24'hffffff << (24 - n));
            if (push)
                exp_q.push_back({j[2:0], w[j]});
        end
        sai_src_model_inst.run(c[2:0] == SAI_FMT_TDM, c[4], c[3], c[5], s, n, w);
        repeat (100) @(posedge clk);
    endtask

    // words left over from the previous setup are dropped, not judged
    task automatic scen(input logic [5:0] c);
        discard = 1'b1;
        sai_src_model_inst.prime(c[3], c[4]);
        repeat (100) @(posedge clk);
        wr(SAI_CTRL_ADDR, {3'h7, c[4:0]});
        rd(SAI_CTRL_ADDR, {3'h0, c[4:0]}, 8'hff);
        discard = 1'b0;
        send(c, 1'b1);
        check("words_missing", 0, exp_q.size());
        // locked by the frame, word clock parked at its last frame level
        rd(SAI_STAT_ADDR, {5'h00, c[4] ^ (c[2:0] == SAI_FMT_TDM), 2'b10}, 8'h06);
    endtask

    // =====================================================================
    // clock, core side of the word stream, watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // random stalls from the core; each word taken while discard is clear is compared in order
    always @(posedge clk) begin
        rnd = lfsr(rnd);
        word_ready <= !hold && rnd[5];
        if (word_valid === 1'b1 && word_ready === 1'b1 && !discard)
            check("word", exp_q.pop_front(), {word_chan, word_data});
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    // =====================================================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        word_ready = 1'b0;
        hold = 1'b0;
        discard = 1'b1;
        rnd = 32'h9451;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(SAI_CTRL_ADDR, SAI_CTRL_RESET, 8'hff);
        wr(12'h7ff, 8'hff);
        rd(12'h7ff, 8'h00, 8'hff);
        rd(SAI_CTRL_ADDR, SAI_CTRL_RESET, 8'hff);
        foreach (cfg[i])
            scen(cfg[i]);
        // core stalls until the buffer overruns, then the flag is cleared
        hold = 1'b1;
        discard = 1'b1;
        repeat (3)
            send(cfg[11], 1'b0);
        rd(SAI_STAT_ADDR, 8'h01, 8'h01);
        wr(SAI_STAT_ADDR, 8'h01);
        rd(SAI_STAT_ADDR, 8'h00, 8'h01);
        hold = 1'b0;
        repeat (100) @(posedge clk);
        complete_run();
    end
endmodule // test_sai_rx
`default_nettype wire
